/* verification/dsc_host_model.sv */
// Host model: drives frames on the serial link and captures readback bits
`default_nettype none
module dsc_host_model (
	output logic o_sclk,
	output logic o_frame_n,
	output logic o_serial_in,
	input wire logic i_serial_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [23:0] rx; // Bits seen on the serial output during the last frame
	// Link idles with clock high and frame inactive
	initial
	begin
		o_sclk = 1'b1;
		o_frame_n = 1'b1;
		o_serial_in = 1'b0;
		rx = 24'h000000;
	end
	// One frame of m bits, MSB first, 32 ns clock period
	task automatic frame(input logic [23:0] w, input int m);
		int i;
		#1.5;
		o_frame_n = 1'b0;
		#16;
		for (i = m - 1; i >= 0; i--)
		begin
			o_serial_in = w[i];
			#16 o_sclk = 1'b0;
			rx = {rx[22:0], i_serial_out};
			#16 o_sclk = 1'b1;
		end
		#16;
		o_serial_in = ~o_serial_in; // Released line shows a changed value
		o_frame_n = 1'b1;
		#16;
	endtask
	// Clock pulses with the frame inactive; they must not count as bits
	task automatic stray(input int m);
		repeat (m)
		begin
			o_serial_in = ~o_serial_in;
			#16 o_sclk = 1'b0;
			#16 o_sclk = 1'b1;
		end
		#16;
	endtask
endmodule
`default_nettype wire

/* verification/tb.sv */
// Self-checking testbench of the serial control pin block
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int WDOG = 200; // Shortened idle timeout
	localparam int DEPTH = 4; // Shortened FIFO
	localparam logic [15:0] CCODE = 16'hA5C3; // Clear code under test
	logic mclk, reset_n, sclk, frame_n, sdi, serial_out, strobe_n, clear, power_on_condition_sel, alert, f_out, f_oe;
	logic [3:0] clear_en, vhiz, vpd, ihiz;
	logic [8:0] src; // Fault sources: temperature, short, open
	logic [3:0][15:0] dac, model, pend;
	int miscompares, comparisons, n, k;
	logic [15:0] d;
	logic [31:0] r;
	// System clock, 4 ns period
	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	dsc_serial_ctrl #(.WDOG_CYCLES(WDOG), .FIFO_DEPTH(DEPTH), .CLEAR_CODE(CCODE)) dut_u (
		.i_mclk(mclk), .i_reset_n(reset_n), .i_sclk(sclk), .i_frame_n(frame_n),
		.i_serial_in(sdi), .o_serial_out(serial_out), .i_load_strobe_n(strobe_n), .i_clear(clear),
		.i_clear_en(clear_en), .i_power_on_condition_sel(power_on_condition_sel), .i_open_circuit(src[3:0]),
		.i_short_circuit(src[7:4]), .i_over_temp(src[8]), .o_alert(alert),
		.o_fault_n_out(f_out), .o_fault_n_oe(f_oe), .o_dac_code(dac), .o_vout_hiz(vhiz),
		.o_vout_pulldown(vpd), .o_iout_hiz(ihiz));
	dsc_host_model host_u (.o_sclk(sclk), .o_frame_n(frame_n), .o_serial_in(sdi),
		.i_serial_out(serial_out));
	// Frame word: readback flag, channel, data
	function automatic logic [23:0] word(input logic rb, input logic [1:0] c, input logic [15:0] v);
		return {rb, c, 5'h00, v};
	endfunction
	// Compare and count
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	// Bounded wait for outputs to reach the expected codes
	task automatic settle();
		for (n = 0; n < 40 && dac !== model; n++)
			@(posedge mclk);
		check(dac, model);
	endtask
	// Outputs must not move
	task automatic hold_chk();
		repeat (20) @(posedge mclk);
		check(dac, model);
	endtask
	// Reset with a given power-on select, then check the starting state
	task automatic do_reset(input logic p);
		@(posedge mclk);
		reset_n <= 1'b0;
		power_on_condition_sel <= p;
		repeat (10) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (3) @(posedge mclk);
		model = '0;
		check({vhiz, ihiz, vpd, alert, f_oe}, {8'hFF, {4{p}}, 2'b00});
		check(dac, model);
	endtask
	// Verdict and end of run
	task automatic close_out();
		$display("Mismatches %0d, comparisons %0d", miscompares, comparisons);
		if (miscompares == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		miscompares = 0;
		comparisons = 0;
		reset_n = 1'b0;
		strobe_n = 1'b0;
		clear = 1'b0;
		power_on_condition_sel = 1'b1;
		clear_en = 4'h0;
		src = 9'h000;
		model = '0;
		r = $urandom(32'h99193C89);
		do_reset(1'b1);
		host_u.stray(3);
		// Writes with the strobe low, corner codes first
		for (k = 0; k < 10; k++)
		begin
			r = $urandom;
			d = (k == 0) ? 16'hFFFF : (k == 1) ? 16'h0000 : r[15:0];
			host_u.frame(word(1'b0, r[17:16], d), 24);
			model[r[17:16]] = d;
			settle();
		end
		// Readback of each channel, answered in the following frame
		for (k = 0; k < 5; k++)
		begin
			host_u.frame(word(1'b1, k[1:0], 16'h0000), 24);
			if (k > 0)
				check(host_u.rx, {model[k - 1], 8'h00});
		end
		// Strobe high: inputs held back until the strobe falls
		@(posedge mclk);
		strobe_n <= 1'b1;
		for (k = 0; k < 4; k++)
		begin
			r = $urandom;
			pend[k] = r[15:0];
			host_u.frame(word(1'b0, k[1:0], r[15:0]), 24);
		end
		hold_chk();
		@(posedge mclk);
		strobe_n <= 1'b0;
		model = pend;
		settle();
		// Idle link raises the alert after the timeout
		host_u.frame(word(1'b0, 2'd1, 16'h1234), 24);
		model[1] = 16'h1234;
		for (n = 0; n < 300 && alert !== 1'b1; n++)
			@(posedge mclk);
		check(n > WDOG - 12 && n <= WDOG + 4, 1'b1);
		host_u.frame(word(1'b1, 2'd0, 16'h0000), 24);
		check(alert, 1'b0);
		settle();
		// Clear on some channels, then writes queue while clear stays high
		r = $urandom;
		@(posedge mclk);
		clear_en <= r[3:0];
		clear <= 1'b1;
		for (k = 0; k < 4; k++)
			if (r[k])
				model[k] = CCODE;
		settle();
		for (k = 0; k <= DEPTH; k++)
			host_u.frame(word(1'b0, 2'd2, 16'h0100 + k[15:0]), 24);
		hold_chk();
		check(f_oe, 1'b1);
		@(posedge mclk);
		clear <= 1'b0;
		model[2] = 16'h0100 + 16'(DEPTH - 1);
		settle();
		// Second reset in mid-run with the other select value
		do_reset(1'b0);
		// Each fault source pulls the fault output
		for (k = 0; k < 9; k++)
		begin
			@(posedge mclk);
			src <= 9'h001 << k;
			for (n = 0; n < 10 && f_oe !== 1'b1; n++)
				@(posedge mclk);
			check({f_oe, f_out}, 2'b10);
			src <= 9'h000;
			repeat (6) @(posedge mclk);
			check(f_oe, 1'b0);
		end
		// Short frame is dropped and flagged
		host_u.frame(word(1'b0, 2'd3, 16'hBEEF), 20);
		hold_chk();
		check(f_oe, 1'b1);
		close_out();
	end
endmodule
`default_nettype wire

/* verilog/dsc_cfg.svh */
// Constants of the serial control pin block: frame layout, timing and reset values
// ==========================================================================
// Overview of operation
// RQ1: Frame sync low brackets every accepted frame
// RQ2: Input bit shifted in at serial clock fall
// RQ3: Serial clock up to 30 MHz captured
// RQ4: Host keeps serial input valid at falls
// RQ5: Readback data shifted out on serial output
// RQ6: Strobe low: output updated at frame end
// RQ7: Strobe high: output waits for strobe fall
// RQ8: Host always drives the load strobe
// RQ9: Clear rising edge loads the clear code
// RQ10: Clear touches only clear-enabled channels
// RQ11: Output writes blocked while clear active
// RQ12: Alert after interface idle for timeout
// RQ13: Fault pulled low on four conditions
// RQ14: Power-on select sampled after every reset
// RQ15: Select zero: voltage and current tristate
// RQ16: Select one: voltage pull-down, current tristate
// RQ17: Low reset input resets logic, resamples select
// RQ18: Clock ignored outside frame, count restarts
// ==========================================================================
`ifndef DSC_CFG_SVH
`define DSC_CFG_SVH

// Frame layout
`define DSC_FRAME_BITS 24
`define DSC_RB_BIT 23
`define DSC_CH_HI 22
`define DSC_CH_LO 21
`define DSC_DATA_HI 15
`define DSC_DATA_LO 0
`define DSC_CHANNELS 4
`define DSC_FIFO_DEPTH 32

// Timing
`define DSC_MCLK_HZ 250000000
`define DSC_SCLK_MAX_HZ 30000000
`define DSC_SCLK_MIN_PERIOD_CYC (`DSC_MCLK_HZ / `DSC_SCLK_MAX_HZ)
`define DSC_WDOG_MS 5
`define DSC_WDOG_CYCLES (`DSC_WDOG_MS * (`DSC_MCLK_HZ / 1000))

// Reset values
`define DSC_CLEAR_CODE 16'h0000
`define DSC_DAC_RESET 16'h0000

`endif

/* verilog/dsc_fifo.sv */
// Frame word FIFO between receiver and output register logic
`default_nettype none
module dsc_fifo import dsc_pkg::*; #(
	parameter int W = 24,
	parameter int DEPTH = 32
)(
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [W-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [W-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH]; // Storage flops
	logic [AW:0] wr_ptr; // Write pointer with wrap bit
	logic [AW:0] rd_ptr; // Read pointer with wrap bit
	logic full;
	logic empty;

	assign empty = (wr_ptr == rd_ptr);
	assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	assign o_in_ready = !full;
	assign o_out_valid = !empty;
	assign o_out_data = mem[rd_ptr[AW-1:0]];

	// ==========================================================
	// Write side
	always_ff @(posedge i_mclk)
	begin
		if (!i_reset_n)
			wr_ptr <= '0;
		else if (i_in_valid && !full)
		begin
			mem[wr_ptr[AW-1:0]] <= i_in_data;
			wr_ptr <= wr_ptr + (AW+1)'(1);
		end
	end

	// ==========================================================
	// Read side
	always_ff @(posedge i_mclk)
	begin
		if (!i_reset_n)
			rd_ptr <= '0;
		else if (i_out_ready && !empty)
			rd_ptr <= rd_ptr + (AW+1)'(1);
	end
endmodule
`default_nettype wire

/* verilog/dsc_pkg.sv */
// Types shared by the serial control pin block
`default_nettype none
package dsc_pkg;
	// Frame receiver state
	typedef enum logic [0:0]
	{
		DSC_IDLE = 1'b0,
		DSC_SHIFT = 1'b1
	} dsc_link_t;
endpackage
`default_nettype wire

/* verilog/dsc_serial_ctrl.sv */
// Serial control pins: frame receiver, readback, load strobe, clear, alert, fault, power-on
`include "dsc_cfg.svh"
`default_nettype none
module dsc_serial_ctrl import dsc_pkg::*; #(
	parameter int WDOG_CYCLES = `DSC_WDOG_CYCLES,
	parameter int FIFO_DEPTH = `DSC_FIFO_DEPTH,
	parameter logic [15:0] CLEAR_CODE = `DSC_CLEAR_CODE
)(
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_sclk,
	input wire logic i_frame_n,
	input wire logic i_serial_in,
	output logic o_serial_out,
	input wire logic i_load_strobe_n,
	input wire logic i_clear,
	input wire logic [3:0] i_clear_en,
	input wire logic i_power_on_condition_sel,
	input wire logic [3:0] i_open_circuit,
	input wire logic [3:0] i_short_circuit,
	input wire logic i_over_temp,
	output logic o_alert,
	output logic o_fault_n_out,
	output logic o_fault_n_oe,
	output logic [3:0][15:0] o_dac_code,
	output logic [3:0] o_vout_hiz,
	output logic [3:0] o_vout_pulldown,
	output logic [3:0] o_iout_hiz
);
	localparam int FB = `DSC_FRAME_BITS;
	localparam int WDW = $clog2(WDOG_CYCLES + 1);

	// ==========================================================
	// Decoding
	function automatic logic [1:0] f_ch(input logic [FB-1:0] w);
		f_ch = w[`DSC_CH_HI:`DSC_CH_LO];
	endfunction

	// ==========================================================
	// Pin synchronisation and edges
	logic s_sclk; // Synced serial clock
	logic s_frame_n; // Synced frame sync
	logic s_sin; // Synced serial input
	logic s_load_strobe_n_n; // Synced load strobe
	logic s_clear; // Synced clear
	logic s_poc; // Synced power-on select
	logic [3:0] s_oc; // Synced open-circuit flags
	logic [3:0] s_sc; // Synced short-circuit flags
	logic s_ot; // Synced overtemperature
	logic p_sclk; // Previous synced levels
	logic p_frame_n;
	logic p_load_strobe_n_n;
	logic p_clear;

	dsc_sync #(.W(15)) u_sync (
		.i_mclk(i_mclk),
		.i_async({i_sclk, i_frame_n, i_serial_in, i_load_strobe_n, i_clear,
			i_power_on_condition_sel, i_open_circuit, i_short_circuit, i_over_temp}),
		.o_sync({s_sclk, s_frame_n, s_sin, s_load_strobe_n_n, s_clear, s_poc, s_oc, s_sc, s_ot})
	);

	// Edge history; in reset it follows the clock, frame and strobe pin levels so none of those edges is false after release; clear history is held low
	always_ff @(posedge i_mclk)
	begin
		if (!i_reset_n)
		begin
			p_sclk <= s_sclk;
			p_frame_n <= s_frame_n;
			p_load_strobe_n_n <= s_load_strobe_n_n;
			p_clear <= 1'b0;
		end
		else
		begin
			p_sclk <= s_sclk;
			p_frame_n <= s_frame_n;
			p_load_strobe_n_n <= s_load_strobe_n_n;
			p_clear <= s_clear;
		end
	end

	logic sclk_fall;
	logic sclk_rise;
	logic frame_fall;
	logic frame_rise;
	logic load_strobe_n_fall;
	logic clear_rise;
	assign sclk_fall = p_sclk && !s_sclk;
	assign sclk_rise = !p_sclk && s_sclk;
	assign frame_fall = p_frame_n && !s_frame_n;
	assign frame_rise = !p_frame_n && s_frame_n;
	assign load_strobe_n_fall = p_load_strobe_n_n && !s_load_strobe_n_n;
	assign clear_rise = !p_clear && s_clear;

	// ==========================================================
	// Frame receiver
	dsc_link_t state; // Receiver state
	logic [FB-1:0] shreg; // Input shift register
	logic [4:0] bit_cnt; // Bits taken this frame
	logic [FB-1:0] out_sh; // Readback shift register
	logic rb_pending; // Readback requested for next frame
	logic [1:0] rb_ch; // Channel to read back
	logic pec_err; // Sticky bad-frame flag
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic good_frame;
	logic [3:0][15:0] dac; // Output data registers

	assign good_frame = (bit_cnt == 5'(FB));
	assign fifo_in_valid = (state == DSC_SHIFT) && frame_rise && good_frame
		&& !shreg[`DSC_RB_BIT]; // [RQ1]

	// State and bit count
	always_ff @(posedge i_mclk)
	begin
		if (!i_reset_n)
		begin
			state <= DSC_IDLE;
			bit_cnt <= '0;
		end
		else if (frame_fall)
		begin
			state <= DSC_SHIFT;
			bit_cnt <= '0; // [RQ18]
		end
		else if (frame_rise)
			state <= DSC_IDLE; // [RQ1]
		else if (state == DSC_SHIFT && sclk_fall && bit_cnt != 5'h1F)
			bit_cnt <= bit_cnt + 5'h01; // [RQ2] [RQ3]
	end

	// Shift input bit on serial clock fall, only inside a frame
	always_ff @(posedge i_mclk)
	begin
		if (!i_reset_n)
			shreg <= '0;
		else if (state == DSC_SHIFT && sclk_fall)
			shreg <= {shreg[FB-2:0], s_sin}; // [RQ2] [RQ18]
	end

	// Readback request and shift out on serial clock rise
	always_ff @(posedge i_mclk)
	begin
		if (!i_reset_n)
		begin
			rb_pending <= 1'b0;
			rb_ch <= 2'h0;
			out_sh <= '0;
		end
		else if (frame_fall)
		begin
			out_sh <= rb_pending ? {dac[rb_ch], 8'h00} : '0; // [RQ5]
			rb_pending <= 1'b0;
		end
		else if (state == DSC_SHIFT && frame_rise && good_frame && shreg[`DSC_RB_BIT])
		begin
			rb_pending <= 1'b1;
			rb_ch <= f_ch(shreg);
		end
		else if (state == DSC_SHIFT && sclk_rise)
			out_sh <= {out_sh[FB-2:0], 1'b0}; // [RQ5]
	end
	assign o_serial_out = out_sh[FB-1];

	// Bad length or overflow marks a packet error until reset
	always_ff @(posedge i_mclk)
	begin
		if (!i_reset_n)
			pec_err <= 1'b0;
		else if (state == DSC_SHIFT && frame_rise
			&& (!good_frame || (!fifo_in_ready && !shreg[`DSC_RB_BIT])))
			pec_err <= 1'b1; // [RQ13]
	end

	// ==========================================================
	// Frame buffer, drained only while clear is inactive
	logic fifo_out_valid;
	logic [FB-1:0] fifo_out_data;
	logic apply;
	assign apply = fifo_out_valid && !s_clear; // [RQ11]

	dsc_fifo #(.W(FB), .DEPTH(FIFO_DEPTH)) u_fifo (
		.i_mclk(i_mclk),
		.i_reset_n(i_reset_n),
		.i_in_valid(fifo_in_valid),
		.o_in_ready(fifo_in_ready),
		.i_in_data(shreg),
		.o_out_valid(fifo_out_valid),
		.i_out_ready(apply),
		.o_out_data(fifo_out_data)
	);

	// ==========================================================
	// Input and output data registers
	logic [3:0][15:0] in_reg; // Channel input registers
	logic [3:0] out_en; // Channel outputs released from power-on state
	logic [1:0] ap_ch;
	assign ap_ch = f_ch(fifo_out_data);

	// Input register write
	always_ff @(posedge i_mclk)
	begin
		if (!i_reset_n)
			in_reg <= {4{`DSC_DAC_RESET}};
		else if (apply)
			in_reg[ap_ch] <= fifo_out_data[`DSC_DATA_HI:`DSC_DATA_LO]; // [RQ7]
	end

	// Output register: clear beats everything, strobe fall loads all channels
	always_ff @(posedge i_mclk)
	begin
		if (!i_reset_n)
		begin
			dac <= {4{`DSC_DAC_RESET}};
			out_en <= 4'h0; // [RQ17]
		end
		else if (clear_rise)
		begin
			for (int i = 0; i < 4; i++)
				if (i_clear_en[i])
					dac[i] <= CLEAR_CODE; // [RQ9] [RQ10]
		end
		else if (!s_clear && load_strobe_n_fall)
		begin
			dac <= in_reg; // [RQ7]
			out_en <= 4'hF;
		end
		else if (apply && !s_load_strobe_n_n)
		begin
			dac[ap_ch] <= fifo_out_data[`DSC_DATA_HI:`DSC_DATA_LO]; // [RQ6]
			out_en[ap_ch] <= 1'b1;
		end
	end
	assign o_dac_code = dac;

	// ==========================================================
	// Power-on condition, caught once after each reset release
	logic power_on_condition_sel; // Sampled select
	logic poc_taken;
	always_ff @(posedge i_mclk)
	begin
		if (!i_reset_n)
		begin
			power_on_condition_sel <= 1'b0;
			poc_taken <= 1'b0; // [RQ17]
		end
		else if (!poc_taken)
		begin
			power_on_condition_sel <= s_poc; // [RQ14]
			poc_taken <= 1'b1;
		end
	end

	// Output stage controls until a channel is first updated
	always_ff @(posedge i_mclk)
	begin
		if (!i_reset_n)
		begin
			o_vout_hiz <= 4'hF;
			o_iout_hiz <= 4'hF;
			o_vout_pulldown <= 4'h0;
		end
		else
		begin
			o_vout_hiz <= ~out_en; // [RQ15]
			o_iout_hiz <= ~out_en; // [RQ15] [RQ16]
			o_vout_pulldown <= ~out_en & {4{power_on_condition_sel && poc_taken}}; // [RQ16]
		end
	end

	// ==========================================================
	// Inactivity alert
	logic [WDW-1:0] wd_cnt; // Idle cycles since last serial clock or frame sync edge
	logic activity;
	assign activity = sclk_rise || sclk_fall || frame_fall || frame_rise;
	always_ff @(posedge i_mclk)
	begin
		if (!i_reset_n || activity)
		begin
			wd_cnt <= '0;
			o_alert <= 1'b0;
		end
		else if (wd_cnt != WDW'(WDOG_CYCLES))
			wd_cnt <= wd_cnt + WDW'(1);
		else
			o_alert <= 1'b1; // [RQ12]
	end

	// ==========================================================
	// Fault output, open drain
	always_ff @(posedge i_mclk)
	begin
		if (!i_reset_n)
			o_fault_n_oe <= 1'b0;
		else
			o_fault_n_oe <= (|s_oc) || (|s_sc) || pec_err || s_ot; // [RQ13]
	end
	assign o_fault_n_out = 1'b0;

	// ==========================================================
	// Checks
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);

	a_frame_push: assert property (state == DSC_SHIFT && frame_rise && bit_cnt == 5'(FB) // [RQ1]
		&& !shreg[`DSC_RB_BIT] && fifo_in_ready |=> fifo_out_valid)
		else $error("complete frame not queued");
	a_shift_bit: assert property (state == DSC_SHIFT && sclk_fall && !frame_rise // [RQ2]
		&& !frame_fall |=> shreg[0] == $past(s_sin))
		else $error("input bit not shifted");
	a_count_step: assert property (state == DSC_SHIFT && !frame_fall // [RQ3]
		|=> bit_cnt - $past(bit_cnt) <= 5'h01)
		else $error("bit count jumped");
	a_readback_shift: assert property (state == DSC_SHIFT && sclk_rise && !frame_fall // [RQ5]
		&& !frame_rise |=> out_sh == {$past(out_sh[FB-2:0]), 1'b0})
		else $error("readback not shifted");
	a_direct_update: assert property (apply && !s_load_strobe_n_n && !clear_rise && !load_strobe_n_fall // [RQ6]
		|=> dac[$past(ap_ch)] == $past(fifo_out_data[15:0]))
		else $error("direct update missed");
	a_deferred_hold: assert property (apply && s_load_strobe_n_n && !clear_rise // [RQ7]
		|=> $stable(dac))
		else $error("output changed with strobe high");
	a_strobe_load: assert property (load_strobe_n_fall && !s_clear |=> dac == $past(in_reg)) // [RQ7]
		else $error("strobe fall did not load");
	a_clear_code: assert property (clear_rise && i_clear_en[0] // [RQ9]
		|=> dac[0] == CLEAR_CODE)
		else $error("clear code not loaded");
	a_clear_skip: assert property (clear_rise && !i_clear_en[1] |=> $stable(dac[1])) // [RQ10]
		else $error("disabled channel cleared");
	a_clear_block: assert property (s_clear |=> $stable(dac) || $past(clear_rise)) // [RQ11]
		else $error("write while clear active");
	a_alert_idle: assert property (wd_cnt == WDW'(WDOG_CYCLES) && !activity // [RQ12]
		|=> o_alert)
		else $error("alert not raised");
	a_alert_drop: assert property (activity |=> !o_alert) // [RQ12]
		else $error("alert held after activity");
	a_fault_pull: assert property (s_ot || pec_err |=> o_fault_n_oe) // [RQ13]
		else $error("fault not pulled");
	a_poc_sample: assert property ($rose(poc_taken) |-> power_on_condition_sel == $past(s_poc)) // [RQ14] [RQ17]
		else $error("power-on select not sampled");
	a_poc_zero: assert property (poc_taken && !power_on_condition_sel && !out_en[0] // [RQ15]
		|=> o_vout_hiz[0] && o_iout_hiz[0] && !o_vout_pulldown[0])
		else $error("select zero state wrong");
	a_poc_one: assert property (poc_taken && power_on_condition_sel && !out_en[0] // [RQ16]
		|=> o_vout_pulldown[0] && o_iout_hiz[0])
		else $error("select one state wrong");
	a_count_restart: assert property (frame_fall |=> bit_cnt == 5'h00) // [RQ18]
		else $error("count not restarted");

	c_direct_write: cover property (apply && !s_load_strobe_n_n);
	c_strobe_load: cover property (load_strobe_n_fall && !s_clear);
	c_clear: cover property (clear_rise && |i_clear_en);
	c_readback: cover property (frame_fall && rb_pending);
	c_alert: cover property ($rose(o_alert));
endmodule
`default_nettype wire

/* verilog/dsc_sync.sv */
// Two-stage synchroniser for pin inputs
`default_nettype none
module dsc_sync import dsc_pkg::*; #(
	parameter int W = 1
)(
	input wire logic i_mclk,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] meta; // First stage, read only by the second

	// ==========================================================
	// Sync chain
	always_ff @(posedge i_mclk)
	begin
		meta <= i_async;
		o_sync <= meta;
	end
endmodule
`default_nettype wire
